// *** logic/timer_clksel_pkg.sv ***
// Constants and types shared by the timer clock and clear select logic.
// Assumes a single 100 MHz clock and an AHB-Lite register port.
package timer_clksel_pkg;

   // =====================================================================
   // Register map (byte offsets)
   localparam logic [7:0] CTRL_CH0_OFFSET  = 8'h00;
   localparam logic [7:0] CTRL_CH1_OFFSET  = 8'h04;
   localparam logic [7:0] CTRL_CH2_OFFSET  = 8'h08;
   localparam logic [7:0] CONFIG_OFFSET    = 8'h0C;
   localparam logic [7:0] COUNT_CH0_OFFSET = 8'h10;
   localparam logic [7:0] COUNT_CH1_OFFSET = 8'h14;
   localparam logic [7:0] COUNT_CH2_OFFSET = 8'h18;

   // =====================================================================
   // Reset values and masks
   localparam logic [7:0]  CTRL_RESET        = 8'h00;
   localparam logic [7:0]  CTRL_CH12_WR_MASK = 8'h7F;
   localparam logic [15:0] COUNT_RESET       = 16'h0000;
   localparam logic [31:0] READ_ZERO         = 32'h0000_0000;

   // =====================================================================
   // Config register field positions
   localparam int START_LSB   = 0;
   localparam int SYNC_LSB    = 4;
   localparam int BUF_C_BIT   = 8;
   localparam int BUF_D_BIT   = 9;
   localparam int PHASE_LSB   = 12;

   // =====================================================================
   // Prescaler: tap bits whose edges give /4, /16, /64, /256, /1024
   localparam int PRESCALE_WIDTH = 10;
   localparam int TAP_DIV4    = 1;
   localparam int TAP_DIV16   = 3;
   localparam int TAP_DIV64   = 5;
   localparam int TAP_DIV256  = 7;
   localparam int TAP_DIV1024 = 9;
   localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_RESET = 10'h000;

   // =====================================================================
   // Field encodings
   localparam logic [2:0] CLR_NONE   = 3'h0;
   localparam logic [2:0] CLR_A      = 3'h1;
   localparam logic [2:0] CLR_B      = 3'h2;
   localparam logic [2:0] CLR_NONE_H = 3'h4;
   localparam logic [2:0] CLR_C      = 3'h5;
   localparam logic [2:0] CLR_D      = 3'h6;
   localparam logic [1:0] CLR_SYNC_LOW = 2'h3;

   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;

   localparam logic [2:0] PSC_DIV1  = 3'h0;
   localparam logic [2:0] PSC_DIV4  = 3'h1;
   localparam logic [2:0] PSC_DIV16 = 3'h2;
   localparam logic [2:0] PSC_DIV64 = 3'h3;
   localparam logic [2:0] PSC_EXT_A = 3'h4;
   localparam logic [2:0] PSC_EXT_B = 3'h5;
   localparam logic [2:0] PSC_CODE6 = 3'h6;
   localparam logic [2:0] PSC_CODE7 = 3'h7;

   // =====================================================================
   // Types
   typedef struct packed {
      logic [2:0] clear_source;
      logic [1:0] edge_select;
      logic [2:0] prescale_sel;
   } counter_control_type;

   typedef struct packed {
      logic rise;
      logic fall;
   } edge_pulse_type;

endpackage

// *** logic/pin_edge_sync.sv ***
// Two-flop synchroniser with edge detection for one external count pin.
// Assumes the pin is asynchronous to clk; pulses are one clk cycle wide.
module pin_edge_sync (
   input  wire logic                             clk,
   input  wire logic                             rst,
   input  wire logic                             pin,
   output timer_clksel_pkg::edge_pulse_type      edges
);

   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // =====================================================================
   // Synchroniser; only sync_reg reads meta_reg
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // =====================================================================
   // Registered edge pulses
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         edges <= '0;
      end else begin
         edges.rise <= sync_reg & ~prev_reg;
         edges.fall <= ~sync_reg & prev_reg;
      end
   end

endmodule

// *** logic/timer_clock_and_clear_select.sv ***
// Clock source, count edge and clear source selection for three 16-bit
// timer channels, with the channel counters and an AHB-Lite register port.
// Assumes compare/capture events and phase counting steps come from
// neighbouring datapath logic on clk; external pins are asynchronous.
//
// Function
// [R01] Control registers 8 bits, reset to zero
// [R02] Software halts counter before changing control
// [R03] Channel 0 clear codes 000 to 011
// [R04] Channel 0 clear codes 100 to 111
// [R05] Buffer-mode C/D never clears counter
// [R06] Sync clear only when sync bit set
// [R07] Channels 1,2 bit 7 reads and writes zero
// [R08] Edge field: rising, falling or both
// [R09] Both edges double prescaled clock rate
// [R10] Undivided clock ignores edge, counts rising
// [R11] Phase counting mode overrides edge field
// [R12] Channel 0 prescaler: four divisions, four pins
// [R13] Channel 1 prescaler incl. divide-by-256, 111 prohibited
// [R14] Channel 2 prescaler incl. divide-by-1024
// [R15] Phase counting mode overrides prescaler field
// [R16] Independent clock selection per channel
// [R17] Channel 0 has no phase counting mode
// [R18] External pins synchronised and edge-detected
// [R19] Prescaled enables are pulses from shared prescaler
// [R20] Clear loads zero instead of increment
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
module timer_clock_and_clear_select (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic               hreadyout,
   output logic [31:0]        hrdata,
   output logic               hresp,
   input  wire logic          ext_count_pin_a,
   input  wire logic          ext_count_pin_b,
   input  wire logic          ext_count_pin_c,
   input  wire logic          ext_count_pin_d,
   input  wire logic [2:0]    match_a,
   input  wire logic [2:0]    match_b,
   input  wire logic          match_c,
   input  wire logic          match_d,
   input  wire logic [1:0]    phase_step,
   input  wire logic [1:0]    phase_down,
   output logic [15:0]        channel_counter_ch0,
   output logic [15:0]        channel_counter_ch1,
   output logic [15:0]        channel_counter_ch2
);

   localparam int PRESCALE_W = timer_clksel_pkg::PRESCALE_WIDTH;

   logic [7:0]  ctrl_reg [3];
   logic [2:0]  start_reg;
   logic [2:0]  sync_reg;
   logic        buf_c_reg;
   logic        buf_d_reg;
   logic [1:0]  phase_reg;
   logic [15:0] count_reg [3];
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic [PRESCALE_W-1:0] psc_reg;
   logic [PRESCALE_W-1:0] psc_prev_reg;
   logic [4:0]  pre_rise;
   logic [4:0]  pre_fall;
   logic [2:0]  direct_clr;
   logic [2:0]  clear_now;
   logic [2:0]  cnt_step;
   logic [31:0] read_value;
   logic        addr_phase;
   timer_clksel_pkg::edge_pulse_type ext_edge [4];

   // =====================================================================
   // AHB-Lite slave: zero wait states, always OKAY
   assign addr_phase = hsel & hready & htrans[1];

   always_comb begin
      read_value = timer_clksel_pkg::READ_ZERO;
      case (haddr[7:0])
         timer_clksel_pkg::CTRL_CH0_OFFSET:  read_value[7:0] = ctrl_reg[0];
         timer_clksel_pkg::CTRL_CH1_OFFSET:  read_value[7:0] = ctrl_reg[1];
         timer_clksel_pkg::CTRL_CH2_OFFSET:  read_value[7:0] = ctrl_reg[2];
         timer_clksel_pkg::CONFIG_OFFSET: begin
            read_value[timer_clksel_pkg::START_LSB +: 3] = start_reg;
            read_value[timer_clksel_pkg::SYNC_LSB +: 3]  = sync_reg;
            read_value[timer_clksel_pkg::BUF_C_BIT]      = buf_c_reg;
            read_value[timer_clksel_pkg::BUF_D_BIT]      = buf_d_reg;
            read_value[timer_clksel_pkg::PHASE_LSB +: 2] = phase_reg;
         end
         timer_clksel_pkg::COUNT_CH0_OFFSET: read_value[15:0] = count_reg[0];
         timer_clksel_pkg::COUNT_CH1_OFFSET: read_value[15:0] = count_reg[1];
         timer_clksel_pkg::COUNT_CH2_OFFSET: read_value[15:0] = count_reg[2];
         default:                            read_value = timer_clksel_pkg::READ_ZERO;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         hrdata      <= timer_clksel_pkg::READ_ZERO;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         wr_pend_reg <= addr_phase & hwrite;
         if (addr_phase) begin
            wr_addr_reg <= haddr[7:0];
         end
         // Read data sampled at the address phase, so it stands in the data phase
         if (addr_phase & ~hwrite) begin
            hrdata <= read_value;
         end
      end
   end

   // =====================================================================
   // Control and config registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg[0] <= timer_clksel_pkg::CTRL_RESET; // R01
         ctrl_reg[1] <= timer_clksel_pkg::CTRL_RESET; // R01
         ctrl_reg[2] <= timer_clksel_pkg::CTRL_RESET; // R01
         start_reg   <= 3'h0;
         sync_reg    <= 3'h0;
         buf_c_reg   <= 1'b0;
         buf_d_reg   <= 1'b0;
         phase_reg   <= 2'h0;
      end else if (wr_pend_reg) begin
         // Writes take effect at once; halting the counter first is up to software
         case (wr_addr_reg)
            timer_clksel_pkg::CTRL_CH0_OFFSET: ctrl_reg[0] <= hwdata[7:0];
            timer_clksel_pkg::CTRL_CH1_OFFSET:
               ctrl_reg[1] <= hwdata[7:0] & timer_clksel_pkg::CTRL_CH12_WR_MASK; // R07
            timer_clksel_pkg::CTRL_CH2_OFFSET:
               ctrl_reg[2] <= hwdata[7:0] & timer_clksel_pkg::CTRL_CH12_WR_MASK; // R07
            timer_clksel_pkg::CONFIG_OFFSET: begin
               start_reg <= hwdata[timer_clksel_pkg::START_LSB +: 3];
               sync_reg  <= hwdata[timer_clksel_pkg::SYNC_LSB +: 3];
               buf_c_reg <= hwdata[timer_clksel_pkg::BUF_C_BIT];
               buf_d_reg <= hwdata[timer_clksel_pkg::BUF_D_BIT];
               phase_reg <= hwdata[timer_clksel_pkg::PHASE_LSB +: 2]; // R17
            end
            default: begin
            end
         endcase
      end
   end

   // =====================================================================
   // Shared free-running prescaler
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         psc_reg      <= timer_clksel_pkg::PRESCALE_RESET;
         psc_prev_reg <= timer_clksel_pkg::PRESCALE_RESET;
      end else begin
         psc_reg      <= psc_reg + 1'b1;
         psc_prev_reg <= psc_reg;
      end
   end

   // One-cycle pulses on each tap edge; all channels share them
   assign pre_rise = {psc_reg[timer_clksel_pkg::TAP_DIV1024] & ~psc_prev_reg[timer_clksel_pkg::TAP_DIV1024],
                      psc_reg[timer_clksel_pkg::TAP_DIV256]  & ~psc_prev_reg[timer_clksel_pkg::TAP_DIV256],
                      psc_reg[timer_clksel_pkg::TAP_DIV64]   & ~psc_prev_reg[timer_clksel_pkg::TAP_DIV64],
                      psc_reg[timer_clksel_pkg::TAP_DIV16]   & ~psc_prev_reg[timer_clksel_pkg::TAP_DIV16],
                      psc_reg[timer_clksel_pkg::TAP_DIV4]    & ~psc_prev_reg[timer_clksel_pkg::TAP_DIV4]}; // R19
   assign pre_fall = {~psc_reg[timer_clksel_pkg::TAP_DIV1024] & psc_prev_reg[timer_clksel_pkg::TAP_DIV1024],
                      ~psc_reg[timer_clksel_pkg::TAP_DIV256]  & psc_prev_reg[timer_clksel_pkg::TAP_DIV256],
                      ~psc_reg[timer_clksel_pkg::TAP_DIV64]   & psc_prev_reg[timer_clksel_pkg::TAP_DIV64],
                      ~psc_reg[timer_clksel_pkg::TAP_DIV16]   & psc_prev_reg[timer_clksel_pkg::TAP_DIV16],
                      ~psc_reg[timer_clksel_pkg::TAP_DIV4]    & psc_prev_reg[timer_clksel_pkg::TAP_DIV4]}; // R19

   // =====================================================================
   // External pins
   pin_edge_sync u_sync_a (.clk(clk), .rst(rst), .pin(ext_count_pin_a), .edges(ext_edge[0])); // R18
   pin_edge_sync u_sync_b (.clk(clk), .rst(rst), .pin(ext_count_pin_b), .edges(ext_edge[1])); // R18
   pin_edge_sync u_sync_c (.clk(clk), .rst(rst), .pin(ext_count_pin_c), .edges(ext_edge[2])); // R18
   pin_edge_sync u_sync_d (.clk(clk), .rst(rst), .pin(ext_count_pin_d), .edges(ext_edge[3])); // R18

   // =====================================================================
   // Per-channel selection and counter
   for (genvar c = 0; c < 3; c++) begin : g_ch
      timer_clksel_pkg::counter_control_type f;
      logic sel_div1;
      logic sel_rise;
      logic sel_fall;
      logic edge_en;
      logic phase_on;
      logic phase_in;
      logic phase_dn;
      logic sync_clr;
      localparam logic [2:0] OWN_MASK = 3'(1 << c);

      assign f = ctrl_reg[c]; // R16

      if (c == 0) begin : g_nophase
         assign phase_on = 1'b0; // R17
         assign phase_in = 1'b0;
         assign phase_dn = 1'b0;
      end else begin : g_phase
         assign phase_on = phase_reg[c-1];
         assign phase_in = phase_step[c-1];
         assign phase_dn = phase_down[c-1];
      end

      always_comb begin
         direct_clr[c] = 1'b0;
         case (f.clear_source)
            timer_clksel_pkg::CLR_A: direct_clr[c] = match_a[c]; // R03
            timer_clksel_pkg::CLR_B: direct_clr[c] = match_b[c]; // R03
            // Buffer-mode general registers C and D never clear the counter
            timer_clksel_pkg::CLR_C:
               direct_clr[c] = (c == 0) & match_c & ~buf_c_reg; // R04 R05
            timer_clksel_pkg::CLR_D:
               direct_clr[c] = (c == 0) & match_d & ~buf_d_reg; // R04 R05
            default: direct_clr[c] = 1'b0; // R03 R04
         endcase
      end

      // Only directly caused clears propagate, so sync channels cannot loop
      assign sync_clr = (f.clear_source[1:0] == timer_clksel_pkg::CLR_SYNC_LOW) & sync_reg[c]
                        & |(direct_clr & sync_reg & ~OWN_MASK); // R06
      assign clear_now[c] = start_reg[c] & (direct_clr[c] | sync_clr);

      always_comb begin
         sel_div1 = 1'b0;
         sel_rise = 1'b0;
         sel_fall = 1'b0;
         case (f.prescale_sel)
            timer_clksel_pkg::PSC_DIV1:  sel_div1 = 1'b1; // R12 R13 R14
            timer_clksel_pkg::PSC_DIV4: begin
               sel_rise = pre_rise[0];
               sel_fall = pre_fall[0];
            end
            timer_clksel_pkg::PSC_DIV16: begin
               sel_rise = pre_rise[1];
               sel_fall = pre_fall[1];
            end
            timer_clksel_pkg::PSC_DIV64: begin
               sel_rise = pre_rise[2];
               sel_fall = pre_fall[2];
            end
            timer_clksel_pkg::PSC_EXT_A: begin
               sel_rise = ext_edge[0].rise;
               sel_fall = ext_edge[0].fall;
            end
            timer_clksel_pkg::PSC_EXT_B: begin
               sel_rise = ext_edge[1].rise;
               sel_fall = ext_edge[1].fall;
            end
            timer_clksel_pkg::PSC_CODE6: begin
               sel_rise = (c == 1) ? pre_rise[3] : ext_edge[2].rise; // R13
               sel_fall = (c == 1) ? pre_fall[3] : ext_edge[2].fall;
            end
            timer_clksel_pkg::PSC_CODE7: begin
               // Prohibited on channel 1: that channel does not count unless phase counting is on
               if (c == 0) begin
                  sel_rise = ext_edge[3].rise; // R12
                  sel_fall = ext_edge[3].fall;
               end else if (c == 2) begin
                  sel_rise = pre_rise[4]; // R14
                  sel_fall = pre_fall[4];
               end
            end
            default: sel_div1 = 1'b0;
         endcase
      end

      always_comb begin
         if (sel_div1) begin
            edge_en = 1'b1; // R10
         end else if (f.edge_select[1]) begin
            edge_en = sel_rise | sel_fall; // R08 R09
         end else if (f.edge_select == timer_clksel_pkg::EDGE_FALL) begin
            edge_en = sel_fall; // R08
         end else begin
            edge_en = sel_rise; // R08
         end
      end

      assign cnt_step[c] = phase_on ? phase_in : edge_en; // R11 R15

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            count_reg[c] <= timer_clksel_pkg::COUNT_RESET;
         end else if (clear_now[c]) begin
            count_reg[c] <= timer_clksel_pkg::COUNT_RESET; // R20
         end else if (start_reg[c] & cnt_step[c]) begin
            count_reg[c] <= (phase_on & phase_dn) ? count_reg[c] - 1'b1 : count_reg[c] + 1'b1;
         end
      end
   end

   assign channel_counter_ch0 = count_reg[0];
   assign channel_counter_ch1 = count_reg[1];
   assign channel_counter_ch2 = count_reg[2];

   // =====================================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_reset_zero;
      $fell(rst) |-> (ctrl_reg[0] == 8'h00) && (ctrl_reg[1] == 8'h00) && (ctrl_reg[2] == 8'h00);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("control not zero after reset"); // R01

   property p_bit7_zero;
      !ctrl_reg[1][7] && !ctrl_reg[2][7];
   endproperty
   a_bit7_zero: assert property (p_bit7_zero) else $error("channel 1/2 bit 7 set"); // R07

   property p_clear_zero;
      clear_now[0] |=> (channel_counter_ch0 == 16'h0000);
   endproperty
   a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero counter"); // R20

   property p_div1_rising;
      (ctrl_reg[0][2:0] == 3'h0) && start_reg[0] && !clear_now[0] && $stable(ctrl_reg[0])
         |=> (channel_counter_ch0 == $past(channel_counter_ch0) + 16'h0001);
   endproperty
   a_div1_rising: assert property (p_div1_rising) else $error("undivided clock not counted"); // R10

   sequence s_both_div4;
      (ctrl_reg[0][4:0] == 5'h11) && cnt_step[0];
   endsequence
   // Setting held over the whole window, so a rewrite cannot look like a lost step
   property p_both_double;
      s_both_div4 ##1 (ctrl_reg[0][4:0] == 5'h11) ##1 (ctrl_reg[0][4:0] == 5'h11)
         |-> !$past(cnt_step[0]) && cnt_step[0];
   endproperty
   a_both_double: assert property (p_both_double) else $error("both-edge rate wrong"); // R09

   property p_buffer_no_clear;
      buf_c_reg && (ctrl_reg[0][7:5] == 3'h5) |-> !clear_now[0];
   endproperty
   a_buffer_no_clear: assert property (p_buffer_no_clear) else $error("buffer reg cleared"); // R05

   property p_sync_needs_bit;
      !sync_reg[0] && (ctrl_reg[0][7:5] == 3'h3) |-> !clear_now[0];
   endproperty
   a_sync_needs_bit: assert property (p_sync_needs_bit) else $error("sync clear without bit"); // R06

   property p_phase_hold;
      phase_reg[0] && !phase_step[0] && !clear_now[1] |=> $stable(channel_counter_ch1);
   endproperty
   a_phase_hold: assert property (p_phase_hold) else $error("phase mode counted idly"); // R11

   sequence s_pin_a_rise;
      (ctrl_reg[0] == 8'h04) && start_reg[0] && !ext_count_pin_a
         ##1 (ctrl_reg[0] == 8'h04) && start_reg[0] && ext_count_pin_a;
   endsequence
   // Two sync flops, the pulse flop and the counter: four edges from pin to count
   property p_ext_count;
      s_pin_a_rise ##1 ((ctrl_reg[0] == 8'h04) && start_reg[0]) [*4]
         |-> (channel_counter_ch0 != $past(channel_counter_ch0, 5));
   endproperty
   a_ext_count: assert property (p_ext_count) else $error("pin edge not counted"); // R18

   property p_pulse_single;
      pre_rise[0] |=> !pre_rise[0];
   endproperty
   a_pulse_single: assert property (p_pulse_single) else $error("prescale pulse too long"); // R19

endmodule

// *** bench/ext_pin_model.sv ***
// External count source model: four asynchronous count pins.
// Assumes one pin is pulsed at a time; idle pins rest low.
module ext_pin_model (
   output logic [3:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;

   initial pins = 4'h0;

   // Odd delays keep pin edges off the clock grid
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         #17 pins[idx] = 1'b1;
         #23 pins[idx] = 1'b0;
      end
      #13;
   endtask
endmodule

// *** bench/timer_clock_and_clear_select_bench.sv ***
// Self-checking bench for the timer clock and clear select block.
// Assumes one 100 MHz clock and a zero-wait AHB-Lite register port.
`define CMP(e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch at %0t: expected %h got %h", $time, e, g); end end

module timer_clock_and_clear_select_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CFG = timer_clksel_pkg::CONFIG_OFFSET;
   // Packed as channel, control value, expected steps in 1024 cycles
   localparam logic [31:0] RATE [13] = '{32'h0000_0400, 32'h0018_0400, 32'h0001_0100,
      32'h0009_0100, 32'h0011_0200, 32'h0002_0040, 32'h0003_0010, 32'h0106_0004,
      32'h0107_0000, 32'h0207_0001, 32'h0217_0002, 32'h011b_0020, 32'h0202_0040};
   // Which event (A, B, C, D, channel 1 A) clears channel 0, per config and code
   localparam logic [4:0] HIT [16] = '{5'h00, 5'h01, 5'h02, 5'h00, 5'h00, 5'h04, 5'h08,
      5'h00, 5'h00, 5'h01, 5'h02, 5'h10, 5'h00, 5'h00, 5'h00, 5'h10};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic [3:0]  pins;
   logic [2:0]  match_a = 3'h0;
   logic [2:0]  match_b = 3'h0;
   logic        match_c = 1'b0;
   logic        match_d = 1'b0;
   logic [1:0]  phase_step = 2'h0;
   logic [1:0]  phase_down = 2'h0;
   logic [15:0] cnt_w [3];
   logic [31:0] exp_q [$];
   logic [31:0] res;
   logic [31:0] seed = 32'h0000_996b;
   logic [15:0] base;
   int          error_cnt = 0;
   int          comparisons = 0;
   event        got;

   timer_clock_and_clear_select dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_count_pin_a(pins[0]),
      .ext_count_pin_b(pins[1]), .ext_count_pin_c(pins[2]), .ext_count_pin_d(pins[3]),
      .match_a(match_a), .match_b(match_b), .match_c(match_c), .match_d(match_d),
      .phase_step(phase_step), .phase_down(phase_down), .channel_counter_ch0(cnt_w[0]),
      .channel_counter_ch1(cnt_w[1]), .channel_counter_ch2(cnt_w[2]));
   ext_pin_model pins_model (.pins(pins));

   always #5 clk = ~clk;

   // ======================================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
         if (k > 16) begin
            error_cnt++;
            tally_and_finish();
         end
      end while (hreadyout !== 1'b1);
   endtask

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h00_0000, a};
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      res = hrdata;
   endtask

   task automatic note(input logic [31:0] e, input logic [31:0] g);
      res = g;
      exp_q.push_back(e);
      -> got;
   endtask

   // All channels stopped while its control changes, then cfg starts the channels it selects
   task automatic arm(input int ch, input logic [7:0] ctl, input logic [31:0] cfg);
      xfer(1'b1, CFG, 32'h0000_0000);
      xfer(1'b1, 8'(ch * 4), {24'h00_0000, ctl});
      xfer(1'b1, CFG, cfg);
      @(posedge clk);
      #1 base = cnt_w[ch];
   endtask

   task automatic span(input int ch, input logic [15:0] e);
      #1 note({16'h0000, e}, {16'h0000, cnt_w[ch] - base});
   endtask

   always @(got) begin
      logic [31:0] e;
      e = exp_q.pop_front();
      `CMP(e, res)
   end

   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end

   // ======================================================================
   // Main sequence
   initial begin
      logic [31:0] r;
      int          n;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, 8'(i * 4 + (i / 3) * 16), 32'h0000_0000);
         note(32'h0000_0000, res | {31'h0, hresp});
      end
      r = rnd();
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, 8'(i * 4), r);
         xfer(1'b0, 8'(i * 4), 32'h0000_0000);
         note({24'h00_0000, r[7:0] & (i == 0 ? 8'hff : 8'h7f)}, res);
      end
      foreach (RATE[i]) begin
         arm(RATE[i][31:24], RATE[i][23:16], 32'h0000_0001 << RATE[i][31:24]);
         repeat (1024) @(posedge clk);
         span(RATE[i][31:24], RATE[i][15:0]);
      end
      for (int i = 0; i < 7; i++) begin
         n = 1 + rnd() % 4;
         arm(i < 4 ? 0 : 2, 8'(4 + i % 4), i < 4 ? 32'h0000_0001 : 32'h0000_0004);
         pins_model.pulse(i % 4, n);
         repeat (8) @(posedge clk);
         span(i < 4 ? 0 : 2, 16'(n));
      end
      xfer(1'b1, 8'h04, 32'h0000_0020);
      for (int b = 0; b < 2; b++) begin
         for (int c = 0; c < 8; c++) begin
            for (int m = 0; m < 5; m++) begin
               arm(0, 8'(c << 5), b ? 32'h0000_0333 : 32'h0000_0023);
               repeat (3) @(posedge clk);
               match_a <= {1'b0, m == 4, m == 0};
               match_b <= {2'h0, m == 1};
               match_c <= m == 2;
               match_d <= m == 3;
               @(posedge clk);
               match_a <= 3'h0;
               match_b <= 3'h0;
               match_c <= 1'b0;
               match_d <= 1'b0;
               #1 note({31'h0, HIT[b * 8 + c][m]}, {31'h0, cnt_w[0] === 16'h0000});
            end
         end
      end
      for (int ch = 1; ch < 3; ch++) begin
         arm(ch, 8'h17, 32'h0000_0800 << ch | 32'h0000_0001 << ch);
         for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            phase_step <= 2'(ch);
            phase_down <= k == 3 ? 2'(ch) : 2'h0;
            @(posedge clk);
            phase_step <= 2'h0;
         end
         repeat (2) @(posedge clk);
         span(ch, 16'h0002);
      end
      repeat (2) @(posedge clk);
      tally_and_finish();
   end
endmodule
